// ### logic/uera_top.sv
`timescale 1ns/10ps
module uera_top #(
	parameter int NUM_EP  = uera_pkg::NUM_EP,
	parameter int NUM_DMA = uera_pkg::NUM_DMA
) (
	// clock and reset
	input  wire logic         sys_clk_in,
	input  wire logic         rst_in,
	// apb slave
	input  wire logic         psel_in,
	input  wire logic         penable_in,
	input  wire logic         pwrite_in,
	input  wire logic [11:0]  paddr_in,
	input  wire logic [31:0]  pwdata_in,
	output logic [31:0]       prdata_out,
	output logic              pready_out,
	output logic              pslverr_out,
	// dma engine side
	input  wire logic [NUM_DMA-1:0] dma_done_in,
	output logic [NUM_DMA-1:0]      dma_run_out,
	output logic                    port_enable_out
);
	localparam int AW = uera_pkg::RAM_AW;

	uera_pkg::uera_epcfg_s        cfg      [NUM_EP];
	logic                         mapd     [NUM_EP];
	logic                         ep_dis   [NUM_EP];
	logic [AW-1:0]                ep_base  [NUM_EP];
	logic [AW-1:0]                ep_bytes [NUM_EP];
	uera_pkg::uera_dmactl_s       dctl     [NUM_DMA];
	logic [1:0]                   dstat    [NUM_DMA];
	logic                         port_enable_bit;
	logic [31:0]                  rd_data;

	logic                         acc;
	logic                         wr;
	logic                         rd;
	logic [3:0]                   grp;
	logic [5:0]                   idx;
	logic                         hit_cfg;
	logic                         hit_dis;
	logic                         hit_base;
	logic                         hit_dctl;
	logic                         hit_dst;
	logic                         hit_bst;
	logic                         hit_ctrl;
	logic                         mapped_ok;

	logic [AW-1:0]                calc_bytes [NUM_EP];
	logic                         calc_legal [NUM_EP];
	logic [uera_pkg::BURST_W-1:0] burst      [NUM_DMA];
	logic [AW+3:0]                total      [NUM_EP+1];

	// apb decode
	assign acc  = psel_in && penable_in;
	assign wr   = acc && pwrite_in;
	assign rd   = acc && !pwrite_in;
	assign grp  = paddr_in[11:8];
	assign idx  = paddr_in[7:2];
	assign hit_ctrl = (paddr_in == uera_pkg::CTRL_OFF);
	assign hit_cfg  = (grp == uera_pkg::EPCFG_BASE[11:8]) && (int'(idx) < NUM_EP);
	assign hit_dis  = (grp == uera_pkg::EPDIS_BASE[11:8]) && (int'(idx) < NUM_EP);
	assign hit_base = (grp == uera_pkg::EPBASE_BASE[11:8]) && (int'(idx) < NUM_EP);
	assign hit_dctl = (grp == uera_pkg::DMACTL_BASE[11:8]) && (int'(idx) < NUM_DMA);
	assign hit_dst  = (grp == uera_pkg::DMAST_BASE[11:8]) && (int'(idx) < NUM_DMA);
	assign hit_bst  = (grp == uera_pkg::DMABST_BASE[11:8]) && (int'(idx) < NUM_DMA);
	assign pready_out  = 1'b1;
	assign pslverr_out = acc && !(hit_ctrl || hit_cfg || hit_dis || hit_base
		|| hit_dctl || hit_dst || hit_bst);
	assign port_enable_out = port_enable_bit;

	// running sum of mapped windows for the capacity check
	assign total[0] = '0;
	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++) begin : g_ep
			uera_alloc_calc u_calc (
				.cfg_in    (cfg[g]),
				.is_ep0_in (g == 0),
				.bytes_out (calc_bytes[g]),
				.legal_out (calc_legal[g])
			);
			assign total[g+1] = total[g] + 17'(mapd[g] ? ep_bytes[g] : '0);
		end
		for (g = 0; g < NUM_DMA; g++) begin : g_dma
			uera_burst_lim u_burst (
				.cfg_in     (cfg[g+1]),
				.buf_len_in (dctl[g].buff_length),
				.burst_out  (burst[g])
			);
			assign dma_run_out[g] = dctl[g].en && port_enable_bit;
		end
	endgenerate

	// legality of the pending write: limits plus total fit, overlap not considered
	uera_pkg::uera_epcfg_s wcfg;
	logic [AW-1:0]         wbytes;
	logic                  wlegal;
	logic [AW+3:0]         others;
	assign wcfg = uera_pkg::uera_epcfg_s'(pwdata_in[7:0]);
	uera_alloc_calc u_wcalc (
		.cfg_in    (wcfg),
		.is_ep0_in (idx == 6'h00),
		.bytes_out (wbytes),
		.legal_out (wlegal)
	);
	assign others = total[NUM_EP] - 17'(mapd[idx[2:0]] ? ep_bytes[idx[2:0]] : '0);
	assign mapped_ok = wlegal
		&& ((others + 17'(wbytes)) <= 17'(uera_pkg::RAM_BYTES));

	// endpoint config, base pointers and window sliding
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < NUM_EP; i++) begin
				cfg[i]      <= '0;
				mapd[i]     <= 1'b0;
				ep_dis[i]   <= 1'b1;
				ep_base[i]  <= '0;
				ep_bytes[i] <= '0;
			end
		end else if (wr && hit_cfg) begin
			// only this entry and the next one change; higher bases stay put
			cfg[idx[2:0]] <= wcfg;
			if (wcfg.bank_count_field != 2'h0) begin
				mapd[idx[2:0]]     <= mapped_ok;
				ep_bytes[idx[2:0]] <= wbytes;
				if (int'(idx) + 1 < NUM_EP)
					ep_base[idx[2:0]+3'h1] <= AW'(ep_base[idx[2:0]] + wbytes);
			end else begin
				mapd[idx[2:0]]     <= 1'b0;
				ep_bytes[idx[2:0]] <= '0;
				if (int'(idx) + 1 < NUM_EP)
					ep_base[idx[2:0]+3'h1] <= ep_base[idx[2:0]];
			end
		end else if (wr && hit_dis) begin
			// only the disable bit moves; config and window are kept
			ep_dis[idx[2:0]] <= pwdata_in[0];
		end
	end

	// port control and dma channels
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			port_enable_bit <= 1'b0;
			for (int i = 0; i < NUM_DMA; i++) begin
				dctl[i]  <= '0;
				dstat[i] <= '0;
			end
		end else begin
			if (wr && hit_ctrl)
				port_enable_bit <= pwdata_in[0];
			for (int i = 0; i < NUM_DMA; i++) begin
				if (!port_enable_bit) begin
					dctl[i] <= '0;
				end else if (wr && hit_dctl && int'(idx) == i) begin
					// zero stops; the clear bit also empties the buffer length
					dctl[i].en <= pwdata_in[uera_pkg::DMA_EN_POS];
					dctl[i].buff_length <= pwdata_in[uera_pkg::DMA_CLR_POS] ? '0 :
						pwdata_in[uera_pkg::DMA_BUF_POS +: uera_pkg::BUFLEN_W];
				end else if (dma_done_in[i]) begin
					dctl[i].en <= 1'b0;
				end
				// done event wins over a clearing read
				if (dma_done_in[i])
					dstat[i] <= 2'h2;
				else if (rd && hit_dst && int'(idx) == i)
					dstat[i] <= 2'h0;
				else
					dstat[i][uera_pkg::ST_BUSY_POS] <= dctl[i].en;
			end
		end
	end

	// read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		if (hit_ctrl)
			rd_data[0] = port_enable_bit;
		else if (hit_cfg) begin
			rd_data[7:0] = cfg[idx[2:0]];
			rd_data[uera_pkg::EP_MAPD_POS] = mapd[idx[2:0]];
		end else if (hit_dis)
			rd_data[0] = ep_dis[idx[2:0]];
		else if (hit_base)
			rd_data = {3'h0, ep_bytes[idx[2:0]], 3'h0, ep_base[idx[2:0]]};
		else if (hit_dctl)
			rd_data = {dctl[idx[2:0]].buff_length, 15'h0000, dctl[idx[2:0]].en};
		else if (hit_dst)
			rd_data = {30'h0, dstat[idx[2:0]]};
		else if (hit_bst)
			rd_data = {23'h0, burst[idx[2:0]]};
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in)
			prdata_out <= 32'h0000_0000;
		else if (psel_in && !penable_in)
			prdata_out <= rd_data;
	end
endmodule

// ### logic/uera_pkg.sv
package uera_pkg;
	localparam int NUM_EP        = 7;
	localparam int NUM_DMA       = 6;
	localparam int RAM_BYTES     = 4096;
	localparam int RAM_AW        = 13;
	localparam int MAX_SZ_CODE   = 7;
	localparam int MAX_BANKS     = 3;
	localparam int BULK_BURST    = 128;
	localparam int ISO_BURST     = 256;
	localparam int BURST_W       = 9;
	localparam int BUFLEN_W      = 16;
	localparam int EP_SIZE_POS   = 0;
	localparam int EP_DIR_POS    = 3;
	localparam int EP_TYPE_POS   = 4;
	localparam int EP_BANK_POS   = 6;
	localparam int EP_MAPD_POS   = 31;
	localparam int DMA_EN_POS    = 0;
	localparam int DMA_CLR_POS   = 1;
	localparam int DMA_BUF_POS   = 16;
	localparam int ST_BUSY_POS   = 0;
	localparam int ST_DONE_POS   = 1;
	localparam logic [11:0] CTRL_OFF    = 12'h000;
	localparam logic [11:0] EPCFG_BASE  = 12'h100;
	localparam logic [11:0] EPDIS_BASE  = 12'h200;
	localparam logic [11:0] EPBASE_BASE = 12'h300;
	localparam logic [11:0] DMACTL_BASE = 12'h400;
	localparam logic [11:0] DMAST_BASE  = 12'h500;
	localparam logic [11:0] DMABST_BASE = 12'h600;
	localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
	localparam logic [1:0]  TYPE_CTRL   = 2'h0;
	localparam logic [1:0]  TYPE_ISO    = 2'h1;

	typedef struct packed {
		logic [1:0] bank_count_field;
		logic [1:0] endpoint_type_field;
		logic       endpoint_direction_field;
		logic [2:0] endpoint_size_field;
	} uera_epcfg_s;

	typedef struct packed {
		logic                  en;
		logic [BUFLEN_W-1:0]   buff_length;
	} uera_dmactl_s;
endpackage

// ### logic/uera_alloc_calc.sv
`timescale 1ns/10ps
module uera_alloc_calc (
	// endpoint configuration
	input  wire uera_pkg::uera_epcfg_s          cfg_in,
	input  wire logic                           is_ep0_in,
	// results
	output logic [uera_pkg::RAM_AW-1:0]         bytes_out,
	output logic                                legal_out
);
	logic [10:0] size_bytes;
	logic        size_ok;
	logic        bank_ok;

	assign size_bytes = 11'(11'h008 << cfg_in.endpoint_size_field);
	// 1024 only for isochronous endpoints
	assign size_ok = (cfg_in.endpoint_size_field < 3'(uera_pkg::MAX_SZ_CODE))
		|| (cfg_in.endpoint_type_field == uera_pkg::TYPE_ISO);
	assign bank_ok = (cfg_in.bank_count_field != 2'h0)
		&& (!is_ep0_in || cfg_in.bank_count_field == 2'h1);
	assign bytes_out = 13'(size_bytes * cfg_in.bank_count_field);
	assign legal_out = size_ok && bank_ok;
endmodule

// ### logic/uera_burst_lim.sv
`timescale 1ns/10ps
module uera_burst_lim (
	// settings
	input  wire uera_pkg::uera_epcfg_s          cfg_in,
	input  wire logic [uera_pkg::BUFLEN_W-1:0]  buf_len_in,
	// result in words
	output logic [uera_pkg::BURST_W-1:0]        burst_out
);
	logic [15:0] ep_words;
	logic [15:0] buf_words;
	logic [15:0] cap;
	logic [15:0] m;

	assign ep_words  = 16'((16'h0008 << cfg_in.endpoint_size_field) >> 2);
	// widened so that a length near the top does not wrap to zero words
	assign buf_words = 16'((17'(buf_len_in) + 17'h00003) >> 2);
	assign cap = (cfg_in.endpoint_type_field == uera_pkg::TYPE_ISO) ?
		16'(uera_pkg::ISO_BURST) : 16'(uera_pkg::BULK_BURST);
	assign m = (ep_words < buf_words) ? ep_words : buf_words;
	assign burst_out = (m < cap) ? 9'(m) : 9'(cap);
endmodule

// ### bench/uera_asserts.sv
`timescale 1ns/10ps
module uera_asserts #(
	parameter int NUM_EP  = uera_pkg::NUM_EP,
	parameter int NUM_DMA = uera_pkg::NUM_DMA
) (
	// watched ports
	input wire logic               sys_clk_in,
	input wire logic               rst_in,
	input wire logic               psel_in,
	input wire logic               penable_in,
	input wire logic               pwrite_in,
	input wire logic [11:0]        paddr_in,
	input wire logic [31:0]        pwdata_in,
	input wire logic [31:0]        prdata_out,
	input wire logic               pready_out,
	input wire logic               pslverr_out,
	input wire logic [NUM_DMA-1:0] dma_done_in,
	input wire logic [NUM_DMA-1:0] dma_run_out,
	input wire logic               port_enable_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	wire       wr  = psel_in & penable_in & pwrite_in;
	wire       rd  = psel_in & penable_in & ~pwrite_in;
	wire [3:0] blk = paddr_in[11:8];
	sequence s_port_write(logic v);
		wr && paddr_in == 12'h000 && pwdata_in[0] == v;
	endsequence
	sequence s_stop0;
		wr && paddr_in == 12'h400 && pwdata_in == 32'h0;
	endsequence
	chk_stop_halts: assert property (s_stop0 |=> !dma_run_out[0])
		else $error("channel kept running after stop");
	chk_port_off: assert property (s_port_write(1'b0) |=> !port_enable_out)
		else $error("port stayed enabled");
	chk_port_on: assert property (s_port_write(1'b1) |=> port_enable_out)
		else $error("port not enabled");
	chk_run_needs_port: assert property (!port_enable_out |-> dma_run_out == '0)
		else $error("channel runs with port off");
	chk_free_unmapped: assert property (rd && blk == 4'h1 && prdata_out[7:6] == 2'h0
		|-> !prdata_out[31])
		else $error("mapped without banks");
	chk_big_not_iso: assert property (rd && blk == 4'h1 && prdata_out[2:0] == 3'h7
		&& prdata_out[5:4] != 2'h1 |-> !prdata_out[31])
		else $error("largest size mapped on non iso");
	chk_ep0_base: assert property (rd && paddr_in == 12'h300 |-> prdata_out[12:0] == 13'h0)
		else $error("endpoint zero moved");
	chk_win_fits: assert property (rd && blk == 4'h3 |-> prdata_out[28:16] <= 13'h1000)
		else $error("window larger than ram");
	chk_burst_max: assert property (rd && blk == 4'h6 |-> prdata_out <= 32'h100)
		else $error("burst too long");
endmodule
bind uera_top uera_asserts #(.NUM_EP(NUM_EP), .NUM_DMA(NUM_DMA)) u_uera_asserts (.sys_clk_in,
	.rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
	.pslverr_out, .dma_done_in, .dma_run_out, .port_enable_out);

// ### bench/uera_dma_model.sv
`timescale 1ns/10ps
module uera_dma_model #(
	parameter int LAT = 5
) (
	// clock and reset
	input  wire logic                         sys_clk_in,
	input  wire logic                         rst_in,
	// channel handshake
	input  wire logic [uera_pkg::NUM_DMA-1:0] dma_run_in,
	output logic [uera_pkg::NUM_DMA-1:0]      dma_done_out
);
	logic [3:0] cnt;
	// each running channel finishes one buffer per lap of the counter
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= 4'h0;
			dma_done_out <= '0;
		end else begin
			cnt <= cnt + 4'h1;
			dma_done_out <= (cnt == 4'(LAT)) ? dma_run_in : '0;
		end
	end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
	logic        sys_clk, rst, psel, penable, pwrite, err, pready, pslverr, port_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [5:0]  done, run;
	int          err_count, num_checks;
	uera_top u_uera_top (.sys_clk_in(sys_clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .dma_done_in(done), .dma_run_out(run),
		.port_enable_out(port_en));
	uera_dma_model u_uera_dma_model (.sys_clk_in(sys_clk), .rst_in(rst), .dma_run_in(run),
		.dma_done_out(done));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask
	task automatic st(input logic [6:0] e);
		@(negedge sys_clk);
		`CHK({port_en, run}, e)
	endtask
	task automatic t_alloc;
		apb(1'b1, 12'h100, 32'h43);
		apb(1'b1, 12'h104, 32'ha6);
		apb(1'b1, 12'h108, 32'h66);
		rdc(12'h100, 32'h8000_0043);
		rdc(12'h304, 32'h0400_0040);
		rdc(12'h308, 32'h0200_0440);
	endtask
	task automatic t_free;
		apb(1'b1, 12'h104, 32'h26);
		rdc(12'h104, 32'h0000_0026);
		rdc(12'h308, 32'h0200_0040);
		rdc(12'h300, 32'h0040_0000);
		apb(1'b1, 12'h104, 32'ha6);
		rdc(12'h308, 32'h0200_0440);
		apb(1'b1, 12'h204, 32'h1);
		rdc(12'h104, 32'h8000_00a6);
		rdc(12'h304, 32'h0400_0040);
	endtask
	task automatic t_mapped;
		apb(1'b1, 12'h10c, 32'h67);
		rdc(12'h10c, 32'h0000_0067);
		apb(1'b1, 12'h10c, 32'hd7);
		rdc(12'h10c, 32'h0000_00d7);
		apb(1'b1, 12'h10c, 32'h97);
		rdc(12'h10c, 32'h8000_0097);
		rdc(12'h30c, 32'h0800_0640);
	endtask
	task automatic t_dma;
		apb(1'b1, 12'h000, 32'h1);
		st(7'h40);
		apb(1'b1, 12'h400, 32'h0040_0000);
		rdc(12'h600, 32'h10);
		apb(1'b1, 12'h400, 32'h1000_0000);
		rdc(12'h600, 32'h80);
		apb(1'b1, 12'h408, 32'hffff_0000);
		rdc(12'h608, 32'h100);
		apb(1'b1, 12'h400, 32'h1000_0001);
		st(7'h41);
		repeat (20) @(posedge sys_clk);
		apb(1'b1, 12'h400, 32'h0);
		st(7'h40);
		apb(1'b0, 12'h500, 32'h0);
		`CHK(q[1], 1'b1)
		apb(1'b0, 12'h500, 32'h0);
		`CHK(q[1], 1'b0)
	endtask
	task automatic t_stop_all;
		logic [11:0] o;
		apb(1'b1, 12'h000, 32'h0);
		st(7'h00);
		apb(1'b1, 12'h400, 32'h1);
		st(7'h00);
		apb(1'b1, 12'h000, 32'h1);
		for (int i = 0; i < 6; i++) begin
			o = 12'(i * 4);
			apb(1'b1, 12'h400 + o, 32'h0);
			apb(1'b1, 12'h204 + o, 32'hffff_ffff);
			apb(1'b1, 12'h104 + o, 32'h0);
			apb(1'b1, 12'h400 + o, 32'h2);
			apb(1'b1, 12'h400 + o, 32'h0);
			apb(1'b0, 12'h500 + o, 32'h0);
			apb(1'b1, 12'h500 + o, q);
		end
		st(7'h40);
		rdc(12'h104, 32'h0);
		apb(1'b0, 12'h7f0, 32'h0);
		`CHK({err, q}, {1'b1, 32'h0})
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		results();
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		t_alloc();
		t_free();
		t_mapped();
		t_dma();
		t_stop_all();
		results();
	end
endmodule
